// ==== rtl/rtc_config_store.sv ====
// Trim configuration store, control register image and serial programming port
`timescale 1ns/100ps

// Summary of operation
// RQ1 - Image loads from store or direct write
// RQ2 - Serial data, clock, write strobe only
// RQ3 - Ten-bit words, only addresses 4-9 used
// RQ4 - Word 9: current, voltage, oscillator trims
// RQ5 - Word 8: buffer gain trim reversed
// RQ6 - Offset trim split across words 8, 7
// RQ7 - Word 7 D5 selects output level
// RQ8 - Word 7 D4-D1 bandwidth code
// RQ9 - Host writes bandwidth codes 0-8 only
// RQ10 - Word 6 D8 is gain select
// RQ11 - Feedback code split over words 6, 5
// RQ12 - Balance code split over words 5, 4
// RQ13 - Word 4 trim code reversed order
// RQ14 - Host keeps feedback capacitance above 1.5pF
// RQ15 - Capacitor codes binary weighted, 20fF step
// RQ16 - Image holds until next load/write
module rtc_config_store
#(
    parameter logic [rtc_pkg::WORD_W-1:0] STORE_INIT = 10'h000
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Serial programming pins
    input wire logic i_ser_data,
    input wire logic i_ser_clk,
    input wire logic i_ser_wr,
    // Decoded settings
    output rtc_pkg::rtc_fields_s o_fields,
    // Capacitor values in femtofarads
    output logic [rtc_pkg::CAP_W-1:0] o_feedback_cap_femto,
    output logic [rtc_pkg::CAP_W-1:0] o_balance_cap_femto,
    output logic [rtc_pkg::CAP_W-1:0] o_trim_cap_femto,
    // Status
    output logic o_image_valid,
    output logic o_range_warn,
    output logic o_frame_taken
);

    localparam int FW = rtc_pkg::FRAME_W;
    localparam int NW = rtc_pkg::NUM_WORDS;
    localparam int WW = rtc_pkg::WORD_W;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic data_lvl;
    logic clk_rise;
    logic wr_rise;

    rtc_sync_edge u_sync_data
    (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_async(i_ser_data),
        .o_level(data_lvl),
        .o_rise()
    );

    rtc_sync_edge u_sync_clk
    (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_async(i_ser_clk),
        .o_level(),
        .o_rise(clk_rise)
    );

    rtc_sync_edge u_sync_wr
    (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_async(i_ser_wr),
        .o_level(),
        .o_rise(wr_rise)
    );

    // ------------------------------------------------------------------
    // Serial frame shifter
    // ------------------------------------------------------------------
    logic [FW-1:0] shift_ff;
    logic [4:0] bit_cnt_ff;
    logic [FW-2:0] shift_low;
    rtc_pkg::rtc_frame_s frame;

    assign shift_low = shift_ff[FW-2:0];
    assign frame = rtc_pkg::rtc_frame_s'(shift_ff);

    // Data and clock share the same synchroniser delay, so the host must
    // hold data steady around its clock edge by a few system cycles.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            shift_ff <= '0;
        end
        else if (clk_rise)
        begin
            shift_ff <= {shift_low, data_lvl}; // RQ2
        end
    end

    // Counter saturates: extra bits push older ones out, last frame wins
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            bit_cnt_ff <= 5'h00;
        end
        else if (wr_rise)
        begin
            bit_cnt_ff <= 5'h00;
        end
        else if (clk_rise && (bit_cnt_ff != rtc_pkg::FRAME_BITS))
        begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------------
    logic commit;
    logic in_range;
    logic store_wr;
    logic img_wr;
    logic reload_cmd;
    rtc_pkg::rtc_idx_t idx;
    logic [WW-1:0] frame_data;

    assign commit = wr_rise && (bit_cnt_ff == rtc_pkg::FRAME_BITS); // RQ2
    assign in_range = rtc_pkg::addr_ok(frame.addr); // RQ3
    assign idx = rtc_pkg::word_idx(frame.addr);
    assign frame_data = frame.data;
    assign store_wr = commit && frame.to_store && in_range; // RQ1
    assign img_wr = commit && !frame.to_store && in_range; // RQ1
    assign reload_cmd = commit && !frame.to_store && (frame.addr == rtc_pkg::ADDR_RELOAD);

    // ------------------------------------------------------------------
    // Nonvolatile store and control register image
    // ------------------------------------------------------------------
    logic [WW-1:0] store_ff [NW];
    logic [WW-1:0] image_ff [NW];
    logic load_req_ff;
    logic image_valid_ff;

    // Flip-flops stand in for the nonvolatile array; reset restores the
    // programmed default, so written contents do not survive a reset.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            for (int i = 0; i < NW; i++)
            begin
                store_ff[i] <= STORE_INIT;
            end
        end
        else if (store_wr)
        begin
            store_ff[idx] <= frame_data; // RQ1
        end
    end

    // Held high through reset so the first edge after release loads
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            load_req_ff <= 1'b1;
        end
        else
        begin
            load_req_ff <= reload_cmd;
        end
    end

    // Direct write wins over a load landing in the same cycle
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            for (int i = 0; i < NW; i++)
            begin
                image_ff[i] <= rtc_pkg::WORD_RESET;
            end
        end
        else
        begin
            if (load_req_ff)
            begin
                for (int i = 0; i < NW; i++)
                begin
                    image_ff[i] <= store_ff[i]; // RQ1
                end
            end
            if (img_wr)
            begin
                image_ff[idx] <= frame_data; // RQ1 RQ16
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            image_valid_ff <= 1'b0;
        end
        else if (load_req_ff || img_wr)
        begin
            image_valid_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Field outputs
    // ------------------------------------------------------------------
    rtc_pkg::rtc_fields_s map_fields;
    rtc_pkg::rtc_fields_s fields_ff;
    logic [rtc_pkg::CAP_W-1:0] fb_cap_ff;
    logic [rtc_pkg::CAP_W-1:0] bal_cap_ff;
    logic [rtc_pkg::CAP_W-1:0] trim_cap_ff;
    logic [rtc_pkg::CAP_W-1:0] nxt_fb_cap;
    logic warn_ff;
    logic taken_ff;

    rtc_field_map u_map
    (
        .i_words(image_ff),
        .o_fields(map_fields)
    );

    assign nxt_fb_cap = rtc_pkg::cap_femto(map_fields.feedback_cap_code);

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            fields_ff <= '0;
            fb_cap_ff <= '0;
            bal_cap_ff <= '0;
            trim_cap_ff <= '0;
        end
        else
        begin
            fields_ff <= map_fields; // RQ16
            fb_cap_ff <= nxt_fb_cap; // RQ15
            bal_cap_ff <= rtc_pkg::cap_femto(WW'(map_fields.balance_cap_code)); // RQ15
            trim_cap_ff <= rtc_pkg::cap_femto(WW'(map_fields.trim_cap_code)); // RQ15
        end
    end

    // Flags settings the host should not use; the device still applies them
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            warn_ff <= 1'b0;
        end
        else
        begin
            warn_ff <= (nxt_fb_cap < rtc_pkg::FB_MIN_FEMTO) ||
                       (map_fields.lowpass_bandwidth_code > rtc_pkg::BW_MAX_CODE); // RQ9 RQ14
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            taken_ff <= 1'b0;
        end
        else
        begin
            taken_ff <= commit && (in_range || reload_cmd);
        end
    end

    assign o_fields = fields_ff;
    assign o_feedback_cap_femto = fb_cap_ff;
    assign o_balance_cap_femto = bal_cap_ff;
    assign o_trim_cap_femto = trim_cap_ff;
    assign o_image_valid = image_valid_ff;
    assign o_range_warn = warn_ff;
    assign o_frame_taken = taken_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [NW*WW-1:0] image_flat;
    logic [NW*WW-1:0] store_flat;
    logic [WW-1:0] w4;
    logic [WW-1:0] w5;
    logic [WW-1:0] w6;
    logic [WW-1:0] w7;
    logic [WW-1:0] w8;
    logic [WW-1:0] w9;

    always_comb
    begin
        image_flat = '0;
        store_flat = '0;
        for (int i = 0; i < NW; i++)
        begin
            image_flat[i*WW +: WW] = image_ff[i];
            store_flat[i*WW +: WW] = store_ff[i];
        end
    end

    assign w4 = image_ff[rtc_pkg::word_idx(rtc_pkg::ADDR_CAP_TAIL)];
    assign w5 = image_ff[rtc_pkg::word_idx(rtc_pkg::ADDR_FB_BAL_CAP)];
    assign w6 = image_ff[rtc_pkg::word_idx(rtc_pkg::ADDR_GSEL_FB)];
    assign w7 = image_ff[rtc_pkg::word_idx(rtc_pkg::ADDR_OFS_BW)];
    assign w8 = image_ff[rtc_pkg::word_idx(rtc_pkg::ADDR_BUF_GAIN)];
    assign w9 = image_ff[rtc_pkg::word_idx(rtc_pkg::ADDR_BIAS_OSC)];

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    sequence s_direct_write;
        img_wr && !load_req_ff;
    endsequence

    sequence s_word_landed;
        ##1 image_ff[$past(idx)] == $past(frame_data);
    endsequence

    a_shift_sample: assert property (clk_rise |=> shift_ff == {$past(shift_low), $past(data_lvl)}) // RQ2
        else $error("serial bit not shifted in");
    a_short_frame: assert property (wr_rise && (bit_cnt_ff != rtc_pkg::FRAME_BITS) && !load_req_ff
        |=> $stable(image_flat) && $stable(store_flat)) // RQ2
        else $error("short frame changed state");
    a_direct_write: assert property (s_direct_write |-> s_word_landed ##1 o_fields == $past(map_fields)) // RQ1
        else $error("direct write not applied");
    a_store_write: assert property (store_wr && !load_req_ff
        |=> store_ff[$past(idx)] == $past(frame_data) && $stable(image_flat)) // RQ1
        else $error("store write wrong or touched image");
    a_load_copy: assert property (load_req_ff && !img_wr |=> image_flat == $past(store_flat)) // RQ1
        else $error("image not loaded from store");
    a_unused_addr: assert property (commit && !in_range && !load_req_ff
        |=> $stable(image_flat) && $stable(store_flat)) // RQ3
        else $error("unused address changed state");
    a_image_hold: assert property (!img_wr && !load_req_ff |=> $stable(image_flat)) // RQ16
        else $error("image changed without load or write");
    a_bias_order: assert property ($stable(image_flat) |-> o_fields.cur_ref_trim == w9[9:7]
        && o_fields.volt_ref_trim == w9[6:3] && o_fields.osc_trim == {w9[0], w9[1], w9[2]}) // RQ4
        else $error("word 9 fields misplaced");
    a_gain_order: assert property ($stable(image_flat) |-> o_fields.buf_gain_trim ==
        {w8[1], w8[2], w8[3], w8[4], w8[5], w8[6], w8[7], w8[8]}) // RQ5
        else $error("buffer gain trim misplaced");
    a_offset_split: assert property ($stable(image_flat) |->
        o_fields.buf_offset_trim == {w7[6], w7[7], w7[8], w7[9], w8[0]}) // RQ6
        else $error("offset trim misplaced");
    a_level_bw: assert property ($stable(image_flat) |-> o_fields.output_level_select == w7[5]
        && o_fields.lowpass_bandwidth_code == w7[4:1]) // RQ7 RQ8
        else $error("level or bandwidth misplaced");
    a_gain_sel: assert property ($stable(image_flat) |-> o_fields.buffer_gain_select == w6[8]) // RQ10
        else $error("gain select misplaced");
    a_cap_split: assert property ($stable(image_flat) |-> o_fields.feedback_cap_code ==
        {w6[6:0], w5[9:7]} && o_fields.balance_cap_code == {w5[6:0], w4[9:8]}) // RQ11 RQ12
        else $error("capacitor code split wrong");
    a_trim_order: assert property ($stable(image_flat) |-> o_fields.trim_cap_code ==
        {w4[2], w4[3], w4[4], w4[5], w4[6], w4[7]}) // RQ13
        else $error("trim capacitor code misplaced");
    a_cap_weight: assert property (##1 o_feedback_cap_femto ==
        rtc_pkg::CAP_W'(o_fields.feedback_cap_code) * rtc_pkg::CAP_STEP_FEMTO) // RQ15
        else $error("feedback capacitance not binary weighted");

endmodule // rtc_config_store

// ==== rtl/rtc_pkg.sv ====
// Shared constants, types and helpers for the readout trim configuration store
package rtc_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int WORD_W = 10;
    localparam int ADDR_W = 4;
    localparam int NUM_WORDS = 6;
    localparam int FRAME_W = 1 + ADDR_W + WORD_W;
    localparam int CAP_W = 16;

    // ------------------------------------------------------------------
    // Word addresses
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CAP_TAIL = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_FB_BAL_CAP = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_GSEL_FB = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_OFS_BW = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_BUF_GAIN = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_BIAS_OSC = 4'h9;
    localparam logic [ADDR_W-1:0] ADDR_RELOAD = 4'hF;

    // ------------------------------------------------------------------
    // Frame and reset values
    // ------------------------------------------------------------------
    localparam logic [4:0] FRAME_BITS = 5'h0F;
    localparam logic [WORD_W-1:0] WORD_RESET = 10'h000;

    // ------------------------------------------------------------------
    // Field positions inside the words
    // ------------------------------------------------------------------
    localparam int P_CUR_LSB = 7;
    localparam int P_VREF_LSB = 3;
    localparam int P_OSC_TOP = 2;
    localparam int P_GAIN_TOP = 8;
    localparam int P_OFS_BIT0 = 0;
    localparam int P_OFS_TOP = 9;
    localparam int P_LEVEL = 5;
    localparam int P_BW_LSB = 1;
    localparam int P_GSEL = 8;
    localparam int P_CF_HI_LSB = 0;
    localparam int P_CF_LO_LSB = 7;
    localparam int P_BAL_HI_LSB = 0;
    localparam int P_BAL_LO_LSB = 8;
    localparam int P_TRIM_TOP = 7;

    // ------------------------------------------------------------------
    // Capacitor weighting and operating limits
    // ------------------------------------------------------------------
    localparam logic [CAP_W-1:0] CAP_STEP_FEMTO = 16'h0014;
    localparam logic [CAP_W-1:0] FB_MIN_FEMTO = 16'h05DC;
    localparam logic [3:0] BW_MAX_CODE = 4'h8;

    typedef logic [2:0] rtc_idx_t;

    typedef struct packed {
        logic to_store;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } rtc_frame_s;

    typedef struct packed {
        logic [2:0] cur_ref_trim;
        logic [3:0] volt_ref_trim;
        logic [2:0] osc_trim;
        logic [7:0] buf_gain_trim;
        logic [4:0] buf_offset_trim;
        logic output_level_select;
        logic [3:0] lowpass_bandwidth_code;
        logic buffer_gain_select;
        logic [9:0] feedback_cap_code;
        logic [8:0] balance_cap_code;
        logic [5:0] trim_cap_code;
    } rtc_fields_s;

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        return (a >= ADDR_CAP_TAIL) && (a <= ADDR_BIAS_OSC);
    endfunction

    function automatic rtc_idx_t word_idx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - ADDR_CAP_TAIL;
        return d[2:0];
    endfunction

    function automatic logic [CAP_W-1:0] cap_femto(input logic [WORD_W-1:0] code);
        return CAP_W'(code) * CAP_STEP_FEMTO;
    endfunction

endpackage

// ==== rtl/rtc_sync_edge.sv ====
// Two-stage synchroniser with rising-edge detect for one pin
`timescale 1ns/100ps

module rtc_sync_edge
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Asynchronous pin
    input wire logic i_async,
    // Synchronised level and edge
    output logic o_level,
    output logic o_rise
);

    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign o_level = sync_ff;
    assign o_rise = sync_ff & ~prev_ff;

endmodule // rtc_sync_edge

// ==== rtl/rtc_field_map.sv ====
// Unpacks the six stored words into named setting fields
`timescale 1ns/100ps

module rtc_field_map
(
    // Control register image
    input wire logic [rtc_pkg::WORD_W-1:0] i_words [rtc_pkg::NUM_WORDS],
    // Decoded fields
    output rtc_pkg::rtc_fields_s o_fields
);

    localparam rtc_pkg::rtc_idx_t I4 = rtc_pkg::word_idx(rtc_pkg::ADDR_CAP_TAIL);
    localparam rtc_pkg::rtc_idx_t I5 = rtc_pkg::word_idx(rtc_pkg::ADDR_FB_BAL_CAP);
    localparam rtc_pkg::rtc_idx_t I6 = rtc_pkg::word_idx(rtc_pkg::ADDR_GSEL_FB);
    localparam rtc_pkg::rtc_idx_t I7 = rtc_pkg::word_idx(rtc_pkg::ADDR_OFS_BW);
    localparam rtc_pkg::rtc_idx_t I8 = rtc_pkg::word_idx(rtc_pkg::ADDR_BUF_GAIN);
    localparam rtc_pkg::rtc_idx_t I9 = rtc_pkg::word_idx(rtc_pkg::ADDR_BIAS_OSC);

    always_comb
    begin
        o_fields = '0;
        o_fields.cur_ref_trim = i_words[I9][rtc_pkg::P_CUR_LSB +: 3]; // RQ4
        o_fields.volt_ref_trim = i_words[I9][rtc_pkg::P_VREF_LSB +: 4]; // RQ4
        for (int i = 0; i < 3; i++)
        begin
            o_fields.osc_trim[i] = i_words[I9][rtc_pkg::P_OSC_TOP - i]; // RQ4
        end
        for (int i = 0; i < 8; i++)
        begin
            o_fields.buf_gain_trim[i] = i_words[I8][rtc_pkg::P_GAIN_TOP - i]; // RQ5
        end
        o_fields.buf_offset_trim[0] = i_words[I8][rtc_pkg::P_OFS_BIT0]; // RQ6
        for (int i = 1; i < 5; i++)
        begin
            o_fields.buf_offset_trim[i] = i_words[I7][rtc_pkg::P_OFS_TOP + 1 - i]; // RQ6
        end
        o_fields.output_level_select = i_words[I7][rtc_pkg::P_LEVEL]; // RQ7
        o_fields.lowpass_bandwidth_code = i_words[I7][rtc_pkg::P_BW_LSB +: 4]; // RQ8
        o_fields.buffer_gain_select = i_words[I6][rtc_pkg::P_GSEL]; // RQ10
        o_fields.feedback_cap_code = {i_words[I6][rtc_pkg::P_CF_HI_LSB +: 7],
                                      i_words[I5][rtc_pkg::P_CF_LO_LSB +: 3]}; // RQ11
        o_fields.balance_cap_code = {i_words[I5][rtc_pkg::P_BAL_HI_LSB +: 7],
                                     i_words[I4][rtc_pkg::P_BAL_LO_LSB +: 2]}; // RQ12
        for (int i = 0; i < 6; i++)
        begin
            o_fields.trim_cap_code[i] = i_words[I4][rtc_pkg::P_TRIM_TOP - i]; // RQ13
        end
    end

endmodule // rtc_field_map

// ==== verif/rtc_host_model.sv ====
// Behavioural host that shifts frames into the serial programming pins
`timescale 1ns/100ps

module rtc_host_model
(
    // Clock
    input wire logic i_clk,
    // Frame request
    input wire logic i_go,
    input wire rtc_pkg::rtc_frame_s i_frame,
    // Serial pins
    output logic o_ser_data,
    output logic o_ser_clk,
    output logic o_ser_wr,
    output logic o_busy
);
    // Serial clock period is eight system clocks (800 ns)
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    initial
    begin
        o_ser_data = 1'b0;
        o_ser_clk = 1'b0;
        o_ser_wr = 1'b0;
        o_busy = 1'b0;
        forever
        begin
            @(posedge i_clk);
            if (i_go === 1'b1)
            begin
                #1;
                o_busy = 1'b1;
                for (int i = rtc_pkg::FRAME_W - 1; i >= 0; i--)
                begin
                    o_ser_data = i_frame[i];
                    tick(2);
                    o_ser_clk = 1'b1;
                    tick(4);
                    o_ser_clk = 1'b0;
                    tick(2);
                end
                // Released data line must not keep showing the last bit
                o_ser_data = ~o_ser_data;
                o_ser_wr = 1'b1;
                tick(4);
                o_ser_wr = 1'b0;
                tick(4);
                o_busy = 1'b0;
            end
        end
    end
endmodule // rtc_host_model

// ==== verif/tb_top.sv ====
// Self-checking testbench for the trim configuration store
`timescale 1ns/100ps

module tb_top;
    logic i_clk;
    logic i_srst;
    logic go;
    logic ser_data;
    logic ser_clk;
    logic ser_wr;
    logic busy;
    logic valid;
    logic warn;
    logic taken;
    logic [9:0] d;
    logic ew;
    logic [15:0] lfsr;
    logic [rtc_pkg::CAP_W-1:0] fb_f;
    logic [rtc_pkg::CAP_W-1:0] bal_f;
    logic [rtc_pkg::CAP_W-1:0] trim_f;
    logic [rtc_pkg::WORD_W-1:0] img [6];
    logic [rtc_pkg::WORD_W-1:0] sto [6];
    rtc_pkg::rtc_frame_s frm;
    rtc_pkg::rtc_fields_s fields;
    rtc_pkg::rtc_fields_s ef;
    rtc_pkg::rtc_fields_s exp_q [$];
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;

    rtc_config_store i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_ser_data(ser_data),
        .i_ser_clk(ser_clk), .i_ser_wr(ser_wr), .o_fields(fields),
        .o_feedback_cap_femto(fb_f), .o_balance_cap_femto(bal_f),
        .o_trim_cap_femto(trim_f), .o_image_valid(valid), .o_range_warn(warn),
        .o_frame_taken(taken));

    rtc_host_model i_host (.i_clk(i_clk), .i_go(go), .i_frame(frm), .o_ser_data(ser_data),
        .o_ser_clk(ser_clk), .o_ser_wr(ser_wr), .o_busy(busy));

    initial i_clk = 1'b0;
    always #50 i_clk = ~i_clk;

    // ------------------------------------------------------------------
    // Reference unpacking of the six words
    // ------------------------------------------------------------------
    function automatic rtc_pkg::rtc_fields_s unpack(input logic [9:0] w [6]);
        rtc_pkg::rtc_fields_s f;
        f.cur_ref_trim = w[5][9:7];
        f.volt_ref_trim = w[5][6:3];
        f.osc_trim = {w[5][0], w[5][1], w[5][2]};
        f.buf_gain_trim = {w[4][1], w[4][2], w[4][3], w[4][4], w[4][5], w[4][6], w[4][7],
            w[4][8]};
        f.buf_offset_trim = {w[3][6], w[3][7], w[3][8], w[3][9], w[4][0]};
        f.output_level_select = w[3][5];
        f.lowpass_bandwidth_code = w[3][4:1];
        f.buffer_gain_select = w[2][8];
        f.feedback_cap_code = {w[2][6:0], w[1][9:7]};
        f.balance_cap_code = {w[1][6:0], w[0][9:8]};
        f.trim_cap_code = {w[0][2], w[0][3], w[0][4], w[0][5], w[0][6], w[0][7]};
        return f;
    endfunction

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic cmp_fields(input rtc_pkg::rtc_fields_s e, input rtc_pkg::rtc_fields_s g);
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED fields exp %h got %h", e, g);
        end
    endtask

    task automatic cmp_val(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic print_verdict();
        if (failures == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Notes the expected image, then has the host shift the frame in
    task automatic send(input logic ts, input logic [3:0] a, input logic [9:0] w);
        if (a >= 4'h4 && a <= 4'h9)
        begin
            if (ts)
                sto[a - 4'h4] = w;
            else
                img[a - 4'h4] = w;
            exp_q.push_back(unpack(img));
        end
        else if (a == 4'hF && !ts)
        begin
            img = sto;
            exp_q.push_back(unpack(img));
        end
        @(posedge i_clk);
        #1;
        frm = '{ts, a, w};
        go = 1'b1;
        @(posedge i_clk);
        #1;
        go = 1'b0;
        @(posedge i_clk);
        #1;
        while (busy === 1'b1)
            @(posedge i_clk);
        repeat (8) @(posedge i_clk);
    endtask

    // Legal words only: bandwidth code 0..8, feedback code at least 512
    task automatic rnd_word(input int a);
        lfsr = lfsr_next(lfsr);
        d = lfsr[9:0];
        if (a == 7)
            d[4:1] = 4'(lfsr[15:12] % 4'h9);
        if (a == 6)
            d[6] = 1'b1;
    endtask

    // ------------------------------------------------------------------
    // Result monitor
    // ------------------------------------------------------------------
    always @(posedge i_clk)
    begin
        #2;
        if (taken === 1'b1)
        begin
            // A reload copies one edge after the pulse, a direct write on the edge that raises it
            repeat (2) @(posedge i_clk);
            #2;
            if (exp_q.size() == 0)
                cmp_val("spurious_taken", 16'h0000, 16'h0001);
            else
            begin
                ef = exp_q.pop_front();
                cmp_fields(ef, fields);
                cmp_val("fb_cap", 16'(ef.feedback_cap_code) * 16'h0014, fb_f);
                cmp_val("bal_cap", 16'(ef.balance_cap_code) * 16'h0014, bal_f);
                cmp_val("trim_cap", 16'(ef.trim_cap_code) * 16'h0014, trim_f);
                // Partly written images may hold a small feedback code
                ew = (16'(ef.feedback_cap_code) * rtc_pkg::CAP_STEP_FEMTO < rtc_pkg::FB_MIN_FEMTO) ||
                    (ef.lowpass_bandwidth_code > rtc_pkg::BW_MAX_CODE);
                cmp_val("warn", 16'(ew), 16'(warn));
            end
        end
    end

    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            print_verdict();
        end
    end

    initial
    begin
        i_srst = 1'b1;
        go = 1'b0;
        frm = '0;
        lfsr = 16'h3052;
        for (int i = 0; i < 6; i++)
        begin
            img[i] = 10'h000;
            sto[i] = 10'h000;
        end
        repeat (10) @(posedge i_clk);
        #1;
        i_srst = 1'b0;
        repeat (6) @(posedge i_clk);
        #1;
        cmp_fields(unpack(sto), fields);
        cmp_val("valid", 16'h0001, 16'(valid));
        for (int r = 0; r < 2; r++)
        begin
            for (int a = 4; a < 10; a++)
            begin
                rnd_word(a);
                send(1'b0, 4'(a), d);
            end
        end
        for (int a = 4; a < 10; a++)
        begin
            rnd_word(a);
            send(1'b1, 4'(a), d);
        end
        send(1'b0, 4'h2, 10'h3FF);
        send(1'b0, 4'hA, 10'h3FF);
        send(1'b1, 4'hF, 10'h155);
        send(1'b0, 4'hF, 10'h000);
        cmp_val("pending", 16'h0000, 16'(exp_q.size()));
        print_verdict();
    end
endmodule // tb_top
